// ---- core/spt_defines.vh ----
// Functional notes
// - Keep total, passes, max, min, mean per section
// - Eight independent sections, each with own settings
// - Offer section share of run time, percent
// - Settings writes ignored while target runs
// - One of four event modes per section
// - Bounding events act on first occurrence only
// - One shared resolution, six steps, 10 ns default
// - Elapsed time in 40-bit counter per resolution tick
// - Pass count in 32-bit counter
// - Measuring starts by itself when target runs
// - Halt stops measuring and presents results
// - Rerun adds onto existing results
// - Clear one section or all sections
// - Durations exact within one resolution period
// - Per-section enable; disabled section never measures
// - Passive only, never touches target execution
`ifndef SPT_DEFINES_VH
`define SPT_DEFINES_VH

`define SPT_CLK_NS        10
`define SPT_RES0_NS       10
`define SPT_RES1_NS       20
`define SPT_RES2_NS       40
`define SPT_RES3_NS       80
`define SPT_RES4_NS       160
`define SPT_RES5_NS       1600
`define SPT_RES_RST       3'h0

`define SPT_MODE_EVT2EVT  2'h0
`define SPT_MODE_EVT2HALT 2'h1
`define SPT_MODE_GO2EVT   2'h2
`define SPT_MODE_GO2HALT  2'h3

`define SPT_REG_CTRL      10'h000
`define SPT_REG_CLEAR     10'h004
`define SPT_REG_STATUS    10'h008
`define SPT_REG_RUN_LO    10'h00c
`define SPT_REG_RUN_HI    10'h010
`define SPT_SEC_FIRST     4'h4
`define SPT_SEC_LAST      4'hb

`define SPT_SO_CFG        4'h0
`define SPT_SO_TOT_LO     4'h1
`define SPT_SO_TOT_HI     4'h2
`define SPT_SO_COUNT      4'h3
`define SPT_SO_MAX_LO     4'h4
`define SPT_SO_MAX_HI     4'h5
`define SPT_SO_MIN_LO     4'h6
`define SPT_SO_MIN_HI     4'h7
`define SPT_SO_AVG_LO     4'h8
`define SPT_SO_AVG_HI     4'h9
`define SPT_SO_RATIO      4'ha

`define SPT_CFG_EN        0
`define SPT_CFG_MODE_LO   1
`define SPT_EVT_COUNT     4'h1
`define SPT_PCT_SCALE     48'h0000_0000_0064

`endif

// ---- core/spt_section.v ----
`timescale 1ns/1ps
`default_nettype none
`include "spt_defines.vh"
module spt_section #(
  parameter TW = 40,
  parameter CW = 32
)(
  input  wire          sys_clk_in,
  input  wire          rstn_in,
  input  wire          tick_in,
  input  wire          running_in,
  input  wire          go_in,
  input  wire          halt_in,
  input  wire          start_evt_in,
  input  wire          end_evt_in,
  input  wire          enable_in,
  input  wire [1:0]    mode_in,
  input  wire          clear_in,
  output reg  [TW-1:0] total_out,
  output reg  [CW-1:0] count_out,
  output reg  [TW-1:0] max_out,
  output reg  [TW-1:0] min_out,
  output reg           active_out
);
  reg  [TW-1:0] dur_q;
  wire          evt_start;
  wire          evt_end;
  wire          begin_w;
  wire          finish_w;
  wire [TW-1:0] dur_fin;

  // Start by event or by program start
  assign evt_start = (mode_in == `SPT_MODE_EVT2EVT) |
                     (mode_in == `SPT_MODE_EVT2HALT);
  assign evt_end   = (mode_in == `SPT_MODE_EVT2EVT) |
                     (mode_in == `SPT_MODE_GO2EVT);
  // First event occurrence opens or closes the pass
  assign begin_w   = enable_in & ~active_out &
                     (evt_start ? (running_in & start_evt_in) : go_in);
  assign finish_w  = active_out &
                     (evt_end ? (running_in & end_evt_in) : halt_in);
  assign dur_fin   = dur_q + {{(TW-1){1'b0}}, tick_in};

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in || clear_in)
    begin
      total_out  <= {TW{1'b0}};
      count_out  <= {CW{1'b0}};
      max_out    <= {TW{1'b0}};
      min_out    <= {TW{1'b1}};
      active_out <= 1'b0;
      dur_q      <= {TW{1'b0}};
    end
    else if (!enable_in)
    begin
      active_out <= 1'b0;
    end
    else if (finish_w)
    begin
      active_out <= 1'b0;
      total_out  <= total_out + dur_fin;
      count_out  <= count_out + {{(CW-1){1'b0}}, 1'b1};
      if (dur_fin > max_out)
        max_out <= dur_fin;
      if (dur_fin < min_out)
        min_out <= dur_fin;
    end
    else if (halt_in)
    begin
      // Unfinished pass at halt is dropped, not counted
      active_out <= 1'b0;
    end
    else if (begin_w)
    begin
      active_out <= 1'b1;
      dur_q      <= {TW{1'b0}};
    end
    else if (active_out && tick_in)
    begin
      dur_q <= dur_q + {{(TW-1){1'b0}}, 1'b1};
    end
  end
endmodule // spt_section
`default_nettype wire

// ---- core/spt_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "spt_defines.vh"
module spt_top #(
  parameter NSEC = 8,
  parameter TW   = 40,
  parameter CW   = 32
)(
  input  wire            sys_clk_in,
  input  wire            rstn_in,
  input  wire [9:0]      avs_address_in,
  input  wire            avs_read_in,
  input  wire            avs_write_in,
  input  wire [31:0]     avs_writedata_in,
  input  wire [3:0]      avs_byteenable_in,
  output reg  [31:0]     avs_readdata_out,
  output reg             avs_waitrequest_out,
  input  wire            run_in,
  input  wire [NSEC-1:0] start_evt_in,
  input  wire [NSEC-1:0] end_evt_in
);
  // Resolution periods in clock cycles
  localparam integer LIM0 = `SPT_RES0_NS / `SPT_CLK_NS;
  localparam integer LIM1 = `SPT_RES1_NS / `SPT_CLK_NS;
  localparam integer LIM2 = `SPT_RES2_NS / `SPT_CLK_NS;
  localparam integer LIM3 = `SPT_RES3_NS / `SPT_CLK_NS;
  localparam integer LIM4 = `SPT_RES4_NS / `SPT_CLK_NS;
  localparam integer LIM5 = `SPT_RES5_NS / `SPT_CLK_NS;

  localparam [1:0] D_IDLE  = 2'h0;
  localparam [1:0] D_LOAD  = 2'h1;
  localparam [1:0] D_ITER  = 2'h2;
  localparam [1:0] D_STORE = 2'h3;

  reg              run_q;
  reg  [2:0]       res_q;
  reg  [7:0]       pre_q;
  reg  [7:0]       lim_d;
  reg  [TW-1:0]    runtime_q;
  reg  [NSEC-1:0]  en_q;
  reg  [2*NSEC-1:0] mode_q;
  reg  [NSEC-1:0]  clr_q;
  reg  [TW-1:0]    avg_q [0:NSEC-1];
  reg  [7:0]       ratio_q [0:NSEC-1];
  reg  [1:0]       dst_q;
  reg  [3:0]       job_q;
  reg  [5:0]       dbit_q;
  reg  [47:0]      dnum_q;
  reg  [40:0]      drem_q;
  reg  [TW-1:0]    dden_q;
  reg              dzero_q;
  reg              ready_q;
  reg  [31:0]      rdata_d;
  integer          i;

  wire             tick;
  wire             go;
  wire             halt;
  wire             bus_req;
  wire             wr_now;
  wire             locked;
  wire [3:0]       sidx;
  wire [2:0]       sec;
  wire             sec_hit;
  wire [3:0]       soff;
  wire [NSEC*TW-1:0] tot_w;
  wire [NSEC*CW-1:0] cnt_w;
  wire [NSEC*TW-1:0] max_w;
  wire [NSEC*TW-1:0] min_w;
  wire [NSEC-1:0]  act_w;
  wire [2:0]       jsec;
  wire [TW-1:0]    jtot;
  wire [CW-1:0]    jcnt;
  wire [47:0]      num_avg;
  wire [47:0]      num_pct;
  wire [40:0]      rsh;
  wire [40:0]      rsub;
  wire             rge;

  // Run/halt edges; run_in is same-clock logic
  assign go   = run_in & ~run_q;
  assign halt = ~run_in & run_q;
  // Settings frozen for the whole run, both edges included
  assign locked = run_in | run_q;

  // One wait state per access; answer on second cycle
  assign bus_req = (avs_read_in | avs_write_in) & avs_waitrequest_out;
  assign wr_now  = avs_write_in & ~avs_waitrequest_out;
  assign sidx    = avs_address_in[9:6] - `SPT_SEC_FIRST;
  assign sec     = sidx[2:0];
  assign sec_hit = (avs_address_in[9:6] >= `SPT_SEC_FIRST) &&
                   (avs_address_in[9:6] <= `SPT_SEC_LAST);
  assign soff    = avs_address_in[5:2];

  always @*
  begin
    case (res_q)
      3'h1:    lim_d = LIM1[7:0];
      3'h2:    lim_d = LIM2[7:0];
      3'h3:    lim_d = LIM3[7:0];
      3'h4:    lim_d = LIM4[7:0];
      3'h5:    lim_d = LIM5[7:0];
      default: lim_d = LIM0[7:0];
    endcase
  end

  // Shared prescaler restarts at program start
  assign tick = run_q && (pre_q == lim_d - 8'h01);

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in || go)
      pre_q <= 8'h00;
    else if (tick)
      pre_q <= 8'h00;
    else if (run_q)
      pre_q <= pre_q + 8'h01;
  end

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      run_q <= 1'b0;
    else
      run_q <= run_in;
  end

  // Go-to-halt time, the denominator of the share
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      runtime_q <= {TW{1'b0}};
    else if (clr_q == {NSEC{1'b1}})
      runtime_q <= {TW{1'b0}};
    else if (tick)
      runtime_q <= runtime_q + {{(TW-1){1'b0}}, 1'b1};
  end

  // Register writes
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      res_q  <= `SPT_RES_RST;
      en_q   <= {NSEC{1'b0}};
      mode_q <= {2*NSEC{1'b0}};
      clr_q  <= {NSEC{1'b0}};
    end
    else
    begin
      clr_q <= {NSEC{1'b0}};
      if (wr_now && avs_byteenable_in[0] && !locked)
      begin
        if (avs_address_in == `SPT_REG_CTRL)
        begin
          if (avs_writedata_in[2:0] <= 3'h5)
            res_q <= avs_writedata_in[2:0];
        end
        else if (avs_address_in == `SPT_REG_CLEAR)
          clr_q <= avs_writedata_in[NSEC-1:0];
        else if (sec_hit && soff == `SPT_SO_CFG)
        begin
          en_q[sec]         <= avs_writedata_in[`SPT_CFG_EN];
          mode_q[2*sec +: 2] <= avs_writedata_in[2:1];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSEC; g = g + 1)
    begin : g_sec
      spt_section #(
        .TW (TW),
        .CW (CW)
      ) u_sec (
        .sys_clk_in   (sys_clk_in),
        .rstn_in      (rstn_in),
        .tick_in      (tick),
        .running_in   (run_q),
        .go_in        (go),
        .halt_in      (halt),
        .start_evt_in (start_evt_in[g]),
        .end_evt_in   (end_evt_in[g]),
        .enable_in    (en_q[g]),
        .mode_in      (mode_q[2*g +: 2]),
        .clear_in     (clr_q[g]),
        .total_out    (tot_w[g*TW +: TW]),
        .count_out    (cnt_w[g*CW +: CW]),
        .max_out      (max_w[g*TW +: TW]),
        .min_out      (min_w[g*TW +: TW]),
        .active_out   (act_w[g])
      );
    end
  endgenerate

  // Serial divider: mean and share for each section after halt
  // Trades 16 x 50 cycles of latency for one small divider
  assign jsec    = job_q[3:1];
  assign jtot    = tot_w[jsec*TW +: TW];
  assign jcnt    = cnt_w[jsec*CW +: CW];
  assign num_avg = {8'h00, jtot};
  assign num_pct = {8'h00, jtot} * `SPT_PCT_SCALE;
  assign rsh     = {drem_q[39:0], dnum_q[47]};
  assign rsub    = rsh - {1'b0, dden_q};
  assign rge     = rsh >= {1'b0, dden_q};

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      dst_q   <= D_IDLE;
      job_q   <= 4'h0;
      dbit_q  <= 6'h00;
      dnum_q  <= 48'h0000_0000_0000;
      drem_q  <= 41'h000_0000_0000;
      dden_q  <= {TW{1'b0}};
      dzero_q <= 1'b0;
      ready_q <= 1'b1;
      for (i = 0; i < NSEC; i = i + 1)
      begin
        avg_q[i]   <= {TW{1'b0}};
        ratio_q[i] <= 8'h00;
      end
    end
    else if (halt || (clr_q != {NSEC{1'b0}}))
    begin
      dst_q   <= D_LOAD;
      job_q   <= 4'h0;
      ready_q <= 1'b0;
    end
    else
    begin
      case (dst_q)
        D_LOAD:
        begin
          dnum_q  <= job_q[0] ? num_pct : num_avg;
          dden_q  <= job_q[0] ? runtime_q : {8'h00, jcnt};
          dzero_q <= job_q[0] ? (runtime_q == {TW{1'b0}})
                              : (jcnt == {CW{1'b0}});
          drem_q  <= 41'h000_0000_0000;
          dbit_q  <= 6'h2f;
          dst_q   <= D_ITER;
        end
        D_ITER:
        begin
          drem_q <= rge ? rsub : rsh;
          dnum_q <= {dnum_q[46:0], rge};
          if (dbit_q == 6'h00)
            dst_q <= D_STORE;
          else
            dbit_q <= dbit_q - 6'h01;
        end
        D_STORE:
        begin
          if (job_q[0])
            ratio_q[jsec] <= dzero_q ? 8'h00 : dnum_q[7:0];
          else
            avg_q[jsec] <= dzero_q ? {TW{1'b0}} : dnum_q[TW-1:0];
          if (job_q == 4'hf)
          begin
            dst_q   <= D_IDLE;
            ready_q <= 1'b1;
          end
          else
          begin
            job_q <= job_q + 4'h1;
            dst_q <= D_LOAD;
          end
        end
        default:
          dst_q <= D_IDLE;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (avs_address_in == `SPT_REG_CTRL)
      rdata_d = {29'h0000_0000, res_q};
    else if (avs_address_in == `SPT_REG_STATUS)
      rdata_d = {16'h0000, act_w, 6'h00, ready_q, run_q};
    else if (avs_address_in == `SPT_REG_RUN_LO)
      rdata_d = runtime_q[31:0];
    else if (avs_address_in == `SPT_REG_RUN_HI)
      rdata_d = {24'h00_0000, runtime_q[TW-1:32]};
    else if (sec_hit)
    begin
      case (soff)
        `SPT_SO_CFG:
          rdata_d = {24'h00_0000, `SPT_EVT_COUNT, 1'b0,
                     mode_q[2*sec +: 2], en_q[sec]};
        `SPT_SO_TOT_LO: rdata_d = tot_w[sec*TW +: 32];
        `SPT_SO_TOT_HI: rdata_d = {24'h00_0000, tot_w[sec*TW+32 +: 8]};
        `SPT_SO_COUNT:  rdata_d = cnt_w[sec*CW +: CW];
        `SPT_SO_MAX_LO: rdata_d = max_w[sec*TW +: 32];
        `SPT_SO_MAX_HI: rdata_d = {24'h00_0000, max_w[sec*TW+32 +: 8]};
        `SPT_SO_MIN_LO: rdata_d = min_w[sec*TW +: 32];
        `SPT_SO_MIN_HI: rdata_d = {24'h00_0000, min_w[sec*TW+32 +: 8]};
        `SPT_SO_AVG_LO: rdata_d = avg_q[sec][31:0];
        `SPT_SO_AVG_HI: rdata_d = {24'h00_0000, avg_q[sec][TW-1:32]};
        `SPT_SO_RATIO:  rdata_d = {24'h00_0000, ratio_q[sec]};
        default:        rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer; target side has no output at all
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end
    else if (bus_req)
    begin
      avs_waitrequest_out <= 1'b0;
      avs_readdata_out    <= avs_read_in ? rdata_d : avs_readdata_out;
    end
    else
    begin
      avs_waitrequest_out <= 1'b1;
    end
  end
endmodule // spt_top
`default_nettype wire

// ---- tb/spt_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spt_defines.vh"
module spt_monitor (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic [9:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        run_in
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic       run_q;
  logic [2:0] res_q;
  logic       ans;
  assign ans = !avs_waitrequest_out;
  // Shadow of the resolution, only moved while halted
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      run_q <= 1'b0;
      res_q <= 3'h0;
    end
    else
    begin
      run_q <= run_in;
      if (ans && avs_write_in && avs_byteenable_in[0] && !run_in && !run_q
          && avs_address_in == `SPT_REG_CTRL
          && avs_writedata_in[2:0] <= 3'h5)
        res_q <= avs_writedata_in[2:0];
    end
  end
  property p_answer;
    (avs_read_in || avs_write_in) && !ans |=> ans;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer after request");
  property p_pulse;
    ans |=> !ans;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer longer than one cycle");
  property p_cause;
    ans |-> $past(avs_read_in || avs_write_in);
  endproperty
  a_cause: assert property (p_cause)
    else $error("answer without request");
  property p_hold;
    !(ans && avs_read_in) |-> $stable(avs_readdata_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved outside a read");
  property p_reset;
    $rose(rstn_in) |-> !ans && avs_readdata_out == 32'h0000_0000;
  endproperty
  a_reset: assert property (p_reset)
    else $error("bus not idle after reset");
  property p_evt_one;
    ans && avs_read_in && avs_address_in[5:0] == 6'h00
    && ^avs_address_in[9:8] |-> avs_readdata_out[7:4] == 4'h1;
  endproperty
  a_evt_one: assert property (p_evt_one)
    else $error("event count not one");
  property p_unmapped;
    ans && avs_read_in && avs_address_in[9:8] == 2'b11
    |-> avs_readdata_out == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_res;
    ans && avs_read_in && avs_address_in == `SPT_REG_CTRL
    |-> avs_readdata_out[2:0] == res_q;
  endproperty
  a_res: assert property (p_res)
    else $error("resolution changed wrongly");
endmodule // spt_monitor
bind spt_top spt_monitor i_spt_monitor (
  .sys_clk_in          (sys_clk_in),
  .rstn_in             (rstn_in),
  .avs_address_in      (avs_address_in),
  .avs_read_in         (avs_read_in),
  .avs_write_in        (avs_write_in),
  .avs_writedata_in    (avs_writedata_in),
  .avs_byteenable_in   (avs_byteenable_in),
  .avs_readdata_out    (avs_readdata_out),
  .avs_waitrequest_out (avs_waitrequest_out),
  .run_in              (run_in)
);
`default_nettype wire

// ---- tb/spt_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spt_link_model (
  input  wire logic       sys_clk_in,
  output var  logic       run_out,
  output var  logic [7:0] start_out,
  output var  logic [7:0] end_out
);
  logic [7:0] st_m [0:511];
  logic [7:0] en_m [0:511];
  task automatic wipe;
    for (int c = 0; c < 512; c++)
    begin
      st_m[c] = 8'h00;
      en_m[c] = 8'h00;
    end
  endtask
  // Fetch events as one-cycle pulses, only inside a run
  task automatic plan(input int c, input int s, input logic e);
    if (e)
      en_m[c][s] = 1'b1;
    else
      st_m[c][s] = 1'b1;
  endtask
  task automatic go(input int len);
    for (int c = 0; c < len; c++)
    begin
      @(posedge sys_clk_in);
      run_out   <= 1'b1;
      start_out <= st_m[c];
      end_out   <= en_m[c];
    end
    @(posedge sys_clk_in);
    run_out   <= 1'b0;
    start_out <= 8'h00;
    end_out   <= 8'h00;
    wipe;
  endtask
  initial
  begin
    run_out   = 1'b0;
    start_out = 8'h00;
    end_out   = 8'h00;
    wipe;
  end
endmodule // spt_link_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spt_defines.vh"
module tb_top;
  logic        sys_clk_in;
  logic        rstn_in;
  logic [9:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic        wreq;
  logic        run;
  logic [7:0]  st;
  logic [7:0]  en;
  logic [31:0] q;
  logic [39:0] v;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          rns [0:5] = '{10, 20, 40, 80, 160, 1600};
  int          xc  [0:4] = '{2, 1, 1, 1, 0};
  int          xt  [0:4] = '{40, 60, 30, 100, 0};
  int          pc  [0:9] = '{5, 15, 20, 30, 50, 60, 40, 30, 5, 15};
  int          ps  [0:9] = '{0, 0, 0, 0, 0, 0, 1, 2, 4, 4};
  logic [9:0]  pe = 10'b10_1011_0010;
  spt_top i_spt_top (
    .sys_clk_in          (sys_clk_in),
    .rstn_in             (rstn_in),
    .avs_address_in      (adr),
    .avs_read_in         (rd),
    .avs_write_in        (wr),
    .avs_writedata_in    (wd),
    .avs_byteenable_in   (4'hf),
    .avs_readdata_out    (rdat),
    .avs_waitrequest_out (wreq),
    .run_in              (run),
    .start_evt_in        (st),
    .end_evt_in          (en)
  );
  spt_link_model i_spt_link (
    .sys_clk_in (sys_clk_in),
    .run_out    (run),
    .start_out  (st),
    .end_out    (en)
  );
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Timer readings may be up to t ticks off either way
  task automatic chk(input logic [39:0] g, input logic [39:0] e,
                     input int t);
    tests_run++;
    if (^g === 1'bx || g > e + t || g + t < e)
    begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk_in);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    // Answer and data taken at the edge that sees waitrequest low
    do
    begin
      @(posedge sys_clk_in);
    end
    while (wreq !== 1'b0);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic w32(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic r32(input logic [9:0] a);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic rd40(input logic [9:0] a);
    logic [31:0] lo;
    bus(1'b0, a, 32'h0000_0000, lo);
    r32(a + 10'h004);
    v = {q[7:0], lo};
  endtask
  function automatic logic [9:0] sa(input int n, input int o);
    return 10'(256 + n * 64 + o * 4);
  endfunction
  // Mean and share are only valid once ready is back
  task automatic settle;
    repeat (8) @(posedge sys_clk_in);
    do
    begin
      r32(`SPT_REG_STATUS);
    end
    while (q[1] !== 1'b1);
  endtask
  task automatic sec(input int n, input int c, input int t, input int tl);
    r32(sa(n, `SPT_SO_COUNT));
    chk(q, c, 0);
    rd40(sa(n, `SPT_SO_TOT_LO));
    chk(v, t, tl);
  endtask
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      tally_and_finish;
    end
  end
  initial
  begin
    rstn_in = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 10'h000;
    wd = 32'h0000_0000;
    repeat (5) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    r32(`SPT_REG_CTRL);
    chk(q, 0, 0);
    rd40(sa(0, `SPT_SO_MIN_LO));
    chk(v, 40'hff_ffff_ffff, 0);
    r32(sa(0, `SPT_SO_CFG));
    chk(q, 16, 0);
    w32(`SPT_REG_CTRL, 32'h0000_0007);
    r32(`SPT_REG_CTRL);
    chk(q, 0, 0);
    w32(10'h300, 32'h0000_0005);
    r32(10'h300);
    chk(q, 0, 0);
    for (int n = 0; n < 4; n++)
      w32(sa(n, `SPT_SO_CFG), 32'(n * 2 + 1));
    for (int i = 0; i < 10; i++)
      i_spt_link.plan(pc[i], ps[i], pe[i]);
    fork
      i_spt_link.go(100);
      begin
        repeat (10) @(posedge sys_clk_in);
        w32(`SPT_REG_CTRL, 32'h0000_0003);
        w32(sa(4, `SPT_SO_CFG), 32'h0000_0001);
      end
    join
    settle;
    for (int n = 0; n < 5; n++)
      sec(n, xc[n], xt[n], 2);
    rd40(sa(0, `SPT_SO_MAX_LO));
    chk(v, 30, 1);
    rd40(sa(0, `SPT_SO_AVG_LO));
    chk(v, 20, 1);
    rd40(sa(4, `SPT_SO_AVG_LO));
    chk(v, 0, 0);
    r32(sa(0, `SPT_SO_RATIO));
    chk(q, 40, 3);
    r32(`SPT_REG_CTRL);
    chk(q, 0, 0);
    rd40(`SPT_REG_RUN_LO);
    chk(v, 100, 1);
    i_spt_link.plan(10, 0, 0);
    i_spt_link.plan(20, 0, 1);
    i_spt_link.go(50);
    settle;
    sec(0, 3, 50, 3);
    sec(3, 2, 150, 2);
    rd40(sa(0, `SPT_SO_MIN_LO));
    chk(v, 10, 1);
    w32(`SPT_REG_CLEAR, 32'h0000_0001);
    settle;
    sec(0, 0, 0, 0);
    rd40(sa(0, `SPT_SO_MIN_LO));
    chk(v, 40'hff_ffff_ffff, 0);
    rd40(sa(0, `SPT_SO_MAX_LO));
    chk(v, 0, 0);
    sec(3, 2, 150, 2);
    w32(`SPT_REG_CLEAR, 32'h0000_00ff);
    settle;
    sec(3, 0, 0, 0);
    for (int r = 0; r < 6; r++)
    begin
      w32(`SPT_REG_CTRL, 32'(r));
      r32(`SPT_REG_CTRL);
      chk(q, r, 0);
      i_spt_link.go(320);
      settle;
      sec(3, 1, 3200 / rns[r], 1);
      w32(`SPT_REG_CLEAR, 32'h0000_00ff);
    end
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
